// ===== cbw_pkg.sv
package cbw_pkg;

  // ----------------------------------------
  // stream markers
  // ----------------------------------------
  localparam logic [7:0] MARK_BYTE = 8'hbb;
  localparam logic [7:0] CODE_X8 = 8'h11;
  localparam logic [7:0] CODE_X16 = 8'h22;
  localparam logic [7:0] CODE_X32 = 8'h44;
  localparam logic [31:0] SYNC_WORD = 32'haa995566;

  // ----------------------------------------
  // sizes and counts
  // ----------------------------------------
  localparam int LANE_W = 8;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  // pin synchronisers plus assembly delay a stall by a few beats
  localparam int FIFO_SLACK = 6;
  localparam logic [5:0] BEATS_X1 = 6'h20;
  localparam logic [5:0] BEATS_X8 = 6'h04;
  localparam logic [5:0] BEATS_X16 = 6'h02;
  localparam logic [5:0] BEATS_X32 = 6'h01;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CBW_W1,
    CBW_W8,
    CBW_W16,
    CBW_W32
  } cbw_width_e;

  typedef enum logic [2:0] {
    CBW_ST_IDLE,
    CBW_ST_MARK,
    CBW_ST_CODE,
    CBW_ST_SYNC,
    CBW_ST_LOCK,
    CBW_ST_DONE
  } cbw_state_e;

endpackage

// ===== cbw_fifo_if.sv
`timescale 1ns/1ps
interface cbw_fifo_if #(
  parameter int W = 32,
  parameter int DEPTH = 32
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [$clog2(DEPTH+1)-1:0] level;

  modport fill (
    output push_valid,
    input push_ready,
    output push_data,
    input pop_valid,
    output pop_ready,
    input pop_data,
    input level
  );

  modport buffer (
    input push_valid,
    output push_ready,
    input push_data,
    output pop_valid,
    input pop_ready,
    output pop_data,
    output level
  );
endinterface

// ===== cbw_fifo.sv
`timescale 1ns/1ps
module cbw_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  cbw_fifo_if.buffer f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] mem_cnt_q;
  logic out_valid_q;
  logic [W-1:0] out_data_q;
  logic push;
  logic load;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  // output register counts as one of the depth words
  assign f.level = mem_cnt_q + CW'(out_valid_q);
  assign f.push_ready = (f.level < CW'(DEPTH));
  assign push = f.push_valid && f.push_ready;
  assign load = (mem_cnt_q != '0) && (!out_valid_q || f.pop_ready);
  assign f.pop_valid = out_valid_q;
  assign f.pop_data = out_data_q;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= f.push_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      mem_cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (load) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      mem_cnt_q <= mem_cnt_q + CW'(push) - CW'(load);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (load) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_ptr_q];
    end else if (f.pop_ready) begin
      out_valid_q <= 1'b0;
    end
  end
endmodule

// ===== cbw_detect.sv
`timescale 1ns/1ps
// Contract
// - parallel modes find bus width from marker pattern ahead of sync word
// - width search looks only at the low byte lane
// - marker 0xbb then 0x11 selects 8-bit bus
// - marker 0xbb then 0x22 selects 16-bit bus
// - marker 0xbb then 0x44 selects 32-bit bus
// - any other byte after marker restarts marker search
// - valid pair switches capture width, then sync search starts
// - serial mode skips width detection entirely
// - sync word match fixes 32-bit word alignment
// - sync word is 0xaa 0x99 0x55 0x66, msb byte first
// - no word is passed on before sync word is found
// - parallel sync search begins only after width detection
// - pins carry each byte bit-reversed against stream value
// - after configuration completes, further data is ignored
// - byte msb sits on data line zero of its lane
// - x16 and x32 reverse bits separately in each lane
module cbw_detect #(
  parameter int DEPTH = cbw_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic attempt_start,
  input wire logic parallel_mode,
  input wire logic cfg_done,
  input wire logic [31:0] pin_data,
  input wire logic pin_strobe,
  input wire logic serial_bit,
  input wire logic serial_strobe,
  output logic pin_busy,
  output logic [31:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic [1:0] bus_width,
  output logic width_locked,
  output logic width_miss,
  output logic sync_found
);
  localparam int DW = cbw_pkg::DATA_W;
  localparam int LW = cbw_pkg::LANE_W;
  localparam int CW = $clog2(DEPTH+1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pin 8*lane carries the stream msb of that lane
  function automatic logic [7:0] lane_byte(input logic [31:0] pins, input int lane);
    logic [7:0] b;
    b = '0;
    for (int j = 0; j < LW; j++) begin
      b[LW-1-j] = pins[lane*LW+j];
    end
    return b;
  endfunction

  // stream order: lane 3 carries the earliest byte on a x32 bus
  function automatic logic [31:0] shift_in(input logic [31:0] win,
                                           input logic [31:0] pins,
                                           input logic sbit,
                                           input cbw_pkg::cbw_width_e w);
    logic [31:0] r;
    r = win;
    case (w)
      cbw_pkg::CBW_W1: r = {win[30:0], sbit};
      cbw_pkg::CBW_W8: r = {win[23:0], lane_byte(pins, 0)};
      cbw_pkg::CBW_W16: r = {win[15:0], lane_byte(pins, 1), lane_byte(pins, 0)};
      cbw_pkg::CBW_W32: r = {lane_byte(pins, 3), lane_byte(pins, 2),
                             lane_byte(pins, 1), lane_byte(pins, 0)};
      default: r = win;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] beats_per_word(input cbw_pkg::cbw_width_e w);
    logic [5:0] n;
    n = cbw_pkg::BEATS_X1;
    case (w)
      cbw_pkg::CBW_W1: n = cbw_pkg::BEATS_X1;
      cbw_pkg::CBW_W8: n = cbw_pkg::BEATS_X8;
      cbw_pkg::CBW_W16: n = cbw_pkg::BEATS_X16;
      cbw_pkg::CBW_W32: n = cbw_pkg::BEATS_X32;
      default: n = cbw_pkg::BEATS_X1;
    endcase
    return n;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [31:0] data_s1_q;
  logic [31:0] data_s2_q;
  logic strobe_s1_q;
  logic strobe_s2_q;
  logic sbit_s1_q;
  logic sbit_s2_q;
  logic sstrobe_s1_q;
  logic sstrobe_s2_q;
  logic mode_s1_q;
  logic mode_s2_q;
  logic start_s1_q;
  logic start_s2_q;
  logic start_s3_q;

  // data and strobe share a stage count so a beat sees its own data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      sbit_s1_q <= 1'b0;
      sbit_s2_q <= 1'b0;
      sstrobe_s1_q <= 1'b0;
      sstrobe_s2_q <= 1'b0;
    end else begin
      data_s1_q <= pin_data;
      data_s2_q <= data_s1_q;
      strobe_s1_q <= pin_strobe;
      strobe_s2_q <= strobe_s1_q;
      sbit_s1_q <= serial_bit;
      sbit_s2_q <= sbit_s1_q;
      sstrobe_s1_q <= serial_strobe;
      sstrobe_s2_q <= sstrobe_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      start_s3_q <= 1'b0;
    end else begin
      mode_s1_q <= parallel_mode;
      mode_s2_q <= mode_s1_q;
      start_s1_q <= attempt_start;
      start_s2_q <= start_s1_q;
      start_s3_q <= start_s2_q;
    end
  end

  logic start_rise;
  logic beat;
  logic [7:0] low_byte;

  assign start_rise = start_s2_q && !start_s3_q;
  // serial modes take the one-bit path, parallel the pin lanes
  assign beat = mode_s2_q ? strobe_s2_q : sstrobe_s2_q;
  assign low_byte = lane_byte(data_s2_q, 0);

  // ----------------------------------------
  // fifo
  // ----------------------------------------
  cbw_fifo_if #(.W(DW), .DEPTH(DEPTH)) fq ();

  cbw_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .f(fq.buffer)
  );

  logic push_valid_q;
  logic [31:0] push_data_q;

  assign fq.push_valid = push_valid_q;
  assign fq.push_data = push_data_q;
  assign fq.pop_ready = word_ready;
  assign word_valid = fq.pop_valid;
  assign word_data = fq.pop_data;

  // ----------------------------------------
  // width and sync state machine
  // ----------------------------------------
  cbw_pkg::cbw_state_e state_q;
  cbw_pkg::cbw_width_e width_q;
  logic [31:0] win_q;
  logic [31:0] win_d;
  logic [5:0] beat_cnt_q;
  logic miss_q;

  assign win_d = shift_in(win_q, data_s2_q, sbit_s2_q, width_q);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= cbw_pkg::CBW_ST_IDLE;
      width_q <= cbw_pkg::CBW_W1;
      miss_q <= 1'b0;
    end else begin
      miss_q <= 1'b0;
      if (start_rise) begin
        // a fresh attempt forgets any earlier width or sync
        state_q <= mode_s2_q ? cbw_pkg::CBW_ST_MARK : cbw_pkg::CBW_ST_SYNC;
        width_q <= mode_s2_q ? cbw_pkg::CBW_W8 : cbw_pkg::CBW_W1;
      end else begin
        case (state_q)
          cbw_pkg::CBW_ST_IDLE: begin
            state_q <= cbw_pkg::CBW_ST_IDLE;
          end
          cbw_pkg::CBW_ST_MARK: begin
            if (beat && low_byte == cbw_pkg::MARK_BYTE) begin
              state_q <= cbw_pkg::CBW_ST_CODE;
            end
          end
          cbw_pkg::CBW_ST_CODE: begin
            if (beat) begin
              case (low_byte)
                cbw_pkg::CODE_X8: begin
                  width_q <= cbw_pkg::CBW_W8;
                  state_q <= cbw_pkg::CBW_ST_SYNC;
                end
                cbw_pkg::CODE_X16: begin
                  width_q <= cbw_pkg::CBW_W16;
                  state_q <= cbw_pkg::CBW_ST_SYNC;
                end
                cbw_pkg::CODE_X32: begin
                  width_q <= cbw_pkg::CBW_W32;
                  state_q <= cbw_pkg::CBW_ST_SYNC;
                end
                default: begin
                  state_q <= cbw_pkg::CBW_ST_MARK;
                  miss_q <= 1'b1;
                end
              endcase
            end
          end
          cbw_pkg::CBW_ST_SYNC: begin
            if (beat && win_d == cbw_pkg::SYNC_WORD) begin
              state_q <= cbw_pkg::CBW_ST_LOCK;
            end
          end
          cbw_pkg::CBW_ST_LOCK: begin
            if (cfg_done) begin
              state_q <= cbw_pkg::CBW_ST_DONE;
            end
          end
          cbw_pkg::CBW_ST_DONE: begin
            state_q <= cbw_pkg::CBW_ST_DONE;
          end
          default: begin
            state_q <= cbw_pkg::CBW_ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // alignment window and word assembly
  // ----------------------------------------
  logic word_end;

  assign word_end = (beat_cnt_q + 6'h01) == beats_per_word(width_q);

  // window only moves while hunting or locked; marker bytes never enter it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= '0;
    end else if (start_rise) begin
      win_q <= '0;
    end else if (beat && (state_q == cbw_pkg::CBW_ST_SYNC ||
                          state_q == cbw_pkg::CBW_ST_LOCK)) begin
      win_q <= win_d;
    end
  end

  // counting starts at zero on the match, so words sit on sync boundaries
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_cnt_q <= '0;
    end else if (start_rise || state_q != cbw_pkg::CBW_ST_LOCK) begin
      beat_cnt_q <= '0;
    end else if (beat) begin
      beat_cnt_q <= word_end ? 6'h00 : beat_cnt_q + 6'h01;
    end
  end

  // only words after the sync match reach the fifo
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      push_valid_q <= 1'b0;
      push_data_q <= '0;
    end else if (state_q == cbw_pkg::CBW_ST_LOCK && !cfg_done && !start_rise &&
                 beat && word_end) begin
      push_valid_q <= 1'b1;
      push_data_q <= win_d;
    end else if (fq.push_ready) begin
      push_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // back-pressure and status
  // ----------------------------------------
  logic busy_q;
  logic locked_q;
  logic sync_q;

  // busy rises early: beats already in the synchronisers still land
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= fq.level >= CW'(DEPTH - cbw_pkg::FIFO_SLACK);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      locked_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (start_rise) begin
      locked_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      locked_q <= state_q == cbw_pkg::CBW_ST_SYNC || state_q == cbw_pkg::CBW_ST_LOCK ||
                  state_q == cbw_pkg::CBW_ST_DONE;
      sync_q <= state_q == cbw_pkg::CBW_ST_LOCK || state_q == cbw_pkg::CBW_ST_DONE;
    end
  end

  assign pin_busy = busy_q;
  assign bus_width = width_q;
  assign width_locked = locked_q;
  assign width_miss = miss_q;
  assign sync_found = sync_q;

endmodule

// ===== cbw_detect_chk.sv
`timescale 1ns/1ps
module cbw_detect_chk #(
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic attempt_start,
  input wire logic parallel_mode,
  input wire logic cfg_done,
  input wire logic [31:0] pin_data,
  input wire logic pin_strobe,
  input wire logic serial_bit,
  input wire logic serial_strobe,
  input wire logic pin_busy,
  input wire logic [31:0] word_data,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic [1:0] bus_width,
  input wire logic width_locked,
  input wire logic width_miss,
  input wire logic sync_found
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_word_after_sync;
    word_valid |-> sync_found;
  endproperty
  a_word_after_sync:
    assert property (p_word_after_sync) else $error("word before sync");

  property p_miss;
    width_miss |-> !width_locked ##1 !width_miss;
  endproperty
  a_miss:
    assert property (p_miss) else $error("bad miss pulse");

  property p_sync_after_lock;
    $rose(sync_found) |-> width_locked;
  endproperty
  a_sync_after_lock:
    assert property (p_sync_after_lock) else $error("sync without width");

  // attempt pin excluded: width reloads on the same edge that clears the status flag
  property p_width_hold;
    width_locked && $past(width_locked) && !attempt_start |-> $stable(bus_width);
  endproperty
  a_width_hold:
    assert property (p_width_hold) else $error("width moved");

  property p_restart;
    $fell(sync_found) |-> $past(attempt_start, 2);
  endproperty
  a_restart:
    assert property (p_restart) else $error("sync lost");

  property p_serial;
    $rose(width_locked) && !parallel_mode |-> bus_width == 2'h0;
  endproperty
  a_serial:
    assert property (p_serial) else $error("serial width");

  property p_parallel;
    $rose(width_locked) && parallel_mode |-> bus_width != 2'h0;
  endproperty
  a_parallel:
    assert property (p_parallel) else $error("parallel width");

  property p_done_quiet;
    cfg_done && $past(cfg_done, 8) && !word_valid |=> !word_valid;
  endproperty
  a_done_quiet:
    assert property (p_done_quiet) else $error("word after done");

  property p_word_hold;
    word_valid && !word_ready |=> word_valid && $stable(word_data);
  endproperty
  a_word_hold:
    assert property (p_word_hold) else $error("word dropped");
endmodule

bind cbw_detect cbw_detect_chk #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .attempt_start(attempt_start),
  .parallel_mode(parallel_mode), .cfg_done(cfg_done), .pin_data(pin_data),
  .pin_strobe(pin_strobe), .serial_bit(serial_bit), .serial_strobe(serial_strobe),
  .pin_busy(pin_busy), .word_data(word_data), .word_valid(word_valid),
  .word_ready(word_ready), .bus_width(bus_width), .width_locked(width_locked),
  .width_miss(width_miss), .sync_found(sync_found)
);

// ===== cbw_src_model.sv
`timescale 1ns/1ps
module cbw_src_model (
  input wire logic core_clk,
  input wire logic pin_busy,
  output logic [31:0] pin_data,
  output logic pin_strobe,
  output logic serial_bit,
  output logic serial_strobe
);
  // msb of each lane on its lowest pin
  function automatic logic [31:0] cbw_rev(input logic [31:0] v);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[(i / 8) * 8 + 7 - (i % 8)];
    end
    return r;
  endfunction

  initial begin
    pin_data = 32'h0;
    pin_strobe = 1'b0;
    serial_bit = 1'b0;
    serial_strobe = 1'b0;
  end

  // released pins flip so stale data never looks valid
  task automatic beat(input logic [31:0] v);
    int n;
    n = 0;
    @(posedge core_clk);
    #1;
    // busy is looked at once settled, never in the edge that updates it
    while (pin_busy && n < 2000) begin
      n++;
      @(posedge core_clk);
      #1;
    end
    pin_data = cbw_rev(v);
    pin_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    pin_strobe = 1'b0;
    pin_data = ~pin_data;
  endtask

  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      #1;
      serial_bit = b[i];
      serial_strobe = 1'b1;
    end
    @(posedge core_clk);
    #1;
    serial_strobe = 1'b0;
    serial_bit = ~serial_bit;
  endtask
endmodule

// ===== tb_config_bus_width_sync_detect.sv
`timescale 1ns/1ps
module tb_config_bus_width_sync_detect;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic attempt_start;
  logic parallel_mode;
  logic cfg_done;
  logic word_ready;
  logic [31:0] pin_data, word_data;
  logic pin_strobe, serial_bit, serial_strobe, pin_busy, word_valid;
  logic [1:0] bus_width;
  logic width_locked, width_miss, sync_found;
  logic [31:0] got_q[$];
  int fail_count = 0;
  int num_checks = 0;
  int miss_seen = 0;

  always #2 core_clk = ~core_clk;

  cbw_detect #(.DEPTH(cbw_pkg::FIFO_DEPTH)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .attempt_start(attempt_start),
    .parallel_mode(parallel_mode), .cfg_done(cfg_done), .pin_data(pin_data),
    .pin_strobe(pin_strobe), .serial_bit(serial_bit), .serial_strobe(serial_strobe),
    .pin_busy(pin_busy), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .bus_width(bus_width), .width_locked(width_locked),
    .width_miss(width_miss), .sync_found(sync_found)
  );

  cbw_src_model src (
    .core_clk(core_clk), .pin_busy(pin_busy), .pin_data(pin_data),
    .pin_strobe(pin_strobe), .serial_bit(serial_bit), .serial_strobe(serial_strobe)
  );

  always @(posedge core_clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) got_q.push_back(word_data);
    if (width_miss === 1'b1) miss_seen++;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_words(input int n);
    int c;
    c = 0;
    while (got_q.size() < n && c < 2000) begin
      c++;
      @(posedge core_clk);
    end
    if (got_q.size() < n) begin
      fail_count++;
      report_and_stop();
    end
    #1;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic attempt(input logic mode);
    @(posedge core_clk);
    #1;
    parallel_mode = mode;
    cfg_done = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    attempt_start = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    attempt_start = 1'b0;
    chk({30'h0, sync_found, width_locked & mode}, 32'h0);
    got_q.delete();
  endtask

  // unused upper lanes carry junk the detector must not see
  task automatic put(input logic [31:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      if (nb == 4) src.beat({24'ha5a5a5, w[8*i+:8]});
      else if (nb == 2) src.beat({16'ha5a5, w[16*i+:16]});
      else src.beat(w);
    end
  endtask

  task automatic t_par(input logic [7:0] code, input int nb, input logic [1:0] w);
    int m;
    int n;
    attempt(1'b1);
    m = miss_seen;
    src.beat(32'h0badcafe);
    src.beat(32'h000000bb);
    src.beat(32'h00000033);
    repeat (6) @(posedge core_clk);
    chk(miss_seen - m, 1);
    src.beat(32'hffffffff);
    src.beat(32'h000000bb);
    src.beat({24'h112200, code});
    src.beat(32'hffffffff);
    src.beat(32'hffffffff);
    repeat (6) @(posedge core_clk);
    chk({30'h0, bus_width}, {30'h0, w});
    chk({30'h0, sync_found, width_locked}, 32'h1);
    chk(got_q.size(), 0);
    put(cbw_pkg::SYNC_WORD, nb);
    put({code, 24'h5a3c96}, nb);
    wait_words(1);
    chk(got_q[0], {code, 24'h5a3c96});
    chk({31'h0, sync_found}, 32'h1);
    word_ready = 1'b0;
    fork
      begin
        for (int k = 0; k < 40; k++) put(32'h100 + k, nb);
      end
    join_none
    n = 0;
    while (pin_busy !== 1'b1 && n < 2000) begin
      n++;
      @(posedge core_clk);
    end
    chk({31'h0, pin_busy}, 32'h1);
    if (n >= 2000) report_and_stop();
    repeat (20) @(posedge core_clk);
    #1;
    word_ready = 1'b1;
    wait_words(41);
    for (int k = 0; k < 40; k++) chk(got_q[k + 1], 32'h100 + k);
    cfg_done = 1'b1;
    put(32'h13572468, nb);
    repeat (20) @(posedge core_clk);
    chk(got_q.size(), 41);
  endtask

  task automatic t_ser();
    logic [7:0] s[$];
    s = '{8'hff, 8'hbb, 8'h11, 8'hff, 8'hff, 8'haa, 8'h99, 8'h55, 8'h66,
          8'h0b, 8'had, 8'hf0, 8'h0d};
    attempt(1'b0);
    foreach (s[i]) src.sbyte(s[i]);
    wait_words(1);
    chk(got_q[0], 32'h0badf00d);
    chk({30'h0, bus_width}, 32'h0);
  endtask

  initial begin
    attempt_start = 1'b0;
    parallel_mode = 1'b1;
    cfg_done = 1'b0;
    word_ready = 1'b1;
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_par(cbw_pkg::CODE_X8, 4, cbw_pkg::CBW_W8);
    t_par(cbw_pkg::CODE_X16, 2, cbw_pkg::CBW_W16);
    t_par(cbw_pkg::CODE_X32, 1, cbw_pkg::CBW_W32);
    t_ser();
    report_and_stop();
  end
endmodule
